// [design/nvm_memory_scanner.sv]
// Program-memory scanner: fetches words over a range and feeds the CRC.
// Assumes a memory read port that returns data within the request cycle and an APB master.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
module nvm_memory_scanner
    import scan_pkg::*;
#(
    parameter logic [15:0] MEM_WORDS = MEM_WORDS_DEFAULT,
    parameter int DATA_W = 14
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Program memory read port
    output logic MEM_REQ_OUT,
    output logic [15:0] MEM_ADDR_OUT,
    input wire logic [DATA_W-1:0] MEM_DATA_IN,
    // CRC client
    input wire logic CRC_READY_IN,
    output logic CRC_VALID_OUT,
    output logic [DATA_W-1:0] CRC_DATA_OUT,
    // System context
    input wire logic IRQ_ACTIVE_IN,
    input wire logic DEBUG_HALT_IN,
    input wire logic LOW_FREQ_INTERNAL_OSC_IN,
    input wire logic TIMER_TWO_POST_OUTPUT_IN,
    input wire logic TIMER_FOUR_POST_OUTPUT_IN,
    input wire logic TIMER_SIX_POST_OUTPUT_IN,
    output logic CPU_STALL_OUT,
    output logic IRQ_OUT
);
    control_t ctl_ff;
    logic [15:0] cur_addr_ff;
    logic [15:0] end_addr_ff;
    logic [1:0] trig_sel_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic pending_ff;
    logic fetch_ff;
    logic trig_prev_ff;
    logic [DATA_W-1:0] crc_data_ff;
    logic crc_valid_ff;
    logic wr_en;
    logic rd_en;
    logic trig_src;
    logic trig_edge;
    logic run_eff;
    logic start_fetch;
    logic done_evt;
    logic addr_invalid;
    logic [31:0] nxt_prdata;

    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH
    } scan_state_t;
    scan_state_t state_ff;

    assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
    assign rd_en = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = 1'b0;

    // Trigger source mux for triggered mode
    always_comb begin
        case (trig_sel_ff)
            2'b11: trig_src = TIMER_SIX_POST_OUTPUT_IN;
            2'b10: trig_src = TIMER_FOUR_POST_OUTPUT_IN;
            2'b01: trig_src = TIMER_TWO_POST_OUTPUT_IN;
            default: trig_src = LOW_FREQ_INTERNAL_OSC_IN;
        endcase
    end
    assign trig_edge = trig_src & ~trig_prev_ff;

    // Addresses at or beyond memory size cannot be fetched
    assign addr_invalid = (cur_addr_ff >= MEM_WORDS);

    // Effective run: suspended by yield during interrupts except in peek mode, bit untouched
    always_comb begin
        run_eff = ctl_ff.enable & ctl_ff.run & ~DEBUG_HALT_IN;
        case (ctl_ff.mode)
            MODE_PEEK: run_eff = run_eff;
            MODE_BURST,
            MODE_CONCURRENT,
            MODE_TRIGGERED: begin
                if (ctl_ff.yield && IRQ_ACTIVE_IN) begin
                    run_eff = 1'b0;
                end
            end
            default: run_eff = 1'b0;
        endcase
    end

    assign start_fetch = run_eff & pending_ff & (state_ff == S_IDLE)
                         & ~addr_invalid
                         & (cur_addr_ff <= end_addr_ff);
    // Frozen under a debug halt: the debugger sees run as it was
    assign done_evt = ctl_ff.run & (state_ff == S_IDLE) & ~DEBUG_HALT_IN
                      & ((cur_addr_ff > end_addr_ff) | addr_invalid);

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_src;
        end
    end

    // Ready request capture; triggered mode also needs a trigger edge
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pending_ff <= 1'b0;
        end else if (!ctl_ff.enable) begin
            pending_ff <= 1'b0;
        end else if (start_fetch) begin
            pending_ff <= 1'b0;
        end else if (CRC_READY_IN && ctl_ff.run && (ctl_ff.mode !=
                     MODE_TRIGGERED || trig_edge)) begin
            pending_ff <= 1'b1;
        end
    end

    // Fetch sequencer: one memory cycle per ready request
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_ff <= S_IDLE;
            fetch_ff <= 1'b0;
        end else if (!ctl_ff.enable) begin
            state_ff <= S_IDLE;
            fetch_ff <= 1'b0;
        end else begin
            case (state_ff)
                S_IDLE: begin
                    fetch_ff <= start_fetch;
                    if (start_fetch) begin
                        state_ff <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    fetch_ff <= 1'b0;
                    if (!DEBUG_HALT_IN) begin
                        state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // Data to the CRC client, captured one cycle after the request
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            crc_data_ff <= '0;
            crc_valid_ff <= 1'b0;
        end else begin
            crc_valid_ff <= fetch_ff;
            if (fetch_ff) begin
                crc_data_ff <= MEM_DATA_IN;
            end
        end
    end

    // Control register; hardware clears run at the end of the range
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctl_ff <= '0;
        end else if (wr_en && PADDR_IN == OFF_CONTROL) begin
            ctl_ff.enable <= PWDATA_IN[BIT_ENABLE];
            ctl_ff.run <= PWDATA_IN[BIT_RUN] & PWDATA_IN[BIT_ENABLE]
                          & ~done_evt;
            ctl_ff.yield <= PWDATA_IN[BIT_YIELD];
            ctl_ff.mode <= access_mode_t'(PWDATA_IN[BIT_MODE_HI:BIT_MODE_LO]);
        end else if (!ctl_ff.enable) begin
            ctl_ff.run <= 1'b0;
        end else if (done_evt) begin
            ctl_ff.run <= 1'b0;
        end
    end

    // Address registers keep their value when enable drops
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            cur_addr_ff <= ADDR_RESET;
            end_addr_ff <= ADDR_RESET;
        end else begin
            if (start_fetch) begin
                cur_addr_ff <= cur_addr_ff + 16'h0001;
            end else if (wr_en && !ctl_ff.run) begin
                if (PADDR_IN == OFF_CUR_HI) begin
                    cur_addr_ff[15:8] <= PWDATA_IN[7:0];
                end
                if (PADDR_IN == OFF_CUR_LO) begin
                    cur_addr_ff[7:0] <= PWDATA_IN[7:0];
                end
            end
            if (wr_en && !ctl_ff.run) begin
                if (PADDR_IN == OFF_END_HI) begin
                    end_addr_ff[15:8] <= PWDATA_IN[7:0];
                end
                if (PADDR_IN == OFF_END_LO) begin
                    end_addr_ff[7:0] <= PWDATA_IN[7:0];
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            trig_sel_ff <= 2'b00;
            irq_mask_ff <= 2'b00;
        end else if (wr_en) begin
            if (PADDR_IN == OFF_TRIG) begin
                trig_sel_ff <= PWDATA_IN[1:0];
            end
            if (PADDR_IN == OFF_IRQ_MASK) begin
                irq_mask_ff <= PWDATA_IN[1:0];
            end
        end
    end

    // Sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            irq_status_ff <= 2'b00;
        end else begin
            if (done_evt) begin
                irq_status_ff[BIT_IRQ_DONE] <= 1'b1;
            end else if (rd_en && PADDR_IN == OFF_IRQ_STATUS) begin
                irq_status_ff[BIT_IRQ_DONE] <= 1'b0;
            end
            if (addr_invalid && ctl_ff.enable) begin
                irq_status_ff[BIT_IRQ_INVALID] <= 1'b1;
            end else if (rd_en && PADDR_IN == OFF_IRQ_STATUS) begin
                irq_status_ff[BIT_IRQ_INVALID] <= 1'b0;
            end
        end
    end

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        case (PADDR_IN)
            OFF_CONTROL: begin
                nxt_prdata[BIT_ENABLE] = ctl_ff.enable;
                nxt_prdata[BIT_RUN] = ctl_ff.run;
                nxt_prdata[BIT_BUSY] = pending_ff
                                       | (state_ff == S_FETCH);
                nxt_prdata[BIT_INVALID] = addr_invalid;
                nxt_prdata[BIT_YIELD] = ctl_ff.yield;
                nxt_prdata[BIT_MODE_HI:BIT_MODE_LO] = ctl_ff.mode;
            end
            OFF_CUR_HI: nxt_prdata[7:0] = cur_addr_ff[15:8];
            OFF_CUR_LO: nxt_prdata[7:0] = cur_addr_ff[7:0];
            OFF_END_HI: nxt_prdata[7:0] = end_addr_ff[15:8];
            OFF_END_LO: nxt_prdata[7:0] = end_addr_ff[7:0];
            OFF_TRIG: nxt_prdata[1:0] = trig_sel_ff;
            OFF_IRQ_STATUS: nxt_prdata[1:0] = irq_status_ff;
            OFF_IRQ_MASK: nxt_prdata[1:0] = irq_mask_ff;
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end
    assign PRDATA_OUT = nxt_prdata;

    assign MEM_REQ_OUT = fetch_ff;
    assign MEM_ADDR_OUT = cur_addr_ff - 16'h0001;
    assign CRC_VALID_OUT = crc_valid_ff;
    assign CRC_DATA_OUT = crc_data_ff;
    // Burst holds the CPU for the whole scan unless yielding to an irq
    assign CPU_STALL_OUT = ctl_ff.enable & ctl_ff.run
                           & (ctl_ff.mode == MODE_BURST)
                           & ~(ctl_ff.yield & IRQ_ACTIVE_IN);
    assign IRQ_OUT = |(irq_status_ff & irq_mask_ff);

    a_fetch_bumps_addr: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) start_fetch |=>
        cur_addr_ff == $past(cur_addr_ff) + 16'h0001)
        else $error("current address did not step on fetch");
    a_fetch_to_crc: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) start_fetch |=> ##1 CRC_VALID_OUT)
        else $error("fetched word not handed to the crc");
    a_done_clears_run: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) done_evt && !wr_en |=> !ctl_ff.run)
        else $error("run stayed set past end address");
    a_done_sets_flag: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) done_evt |=> irq_status_ff[0])
        else $error("completion flag not set");
    a_disable_resets: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) !ctl_ff.enable && !wr_en
        |=> state_ff == S_IDLE && !pending_ff)
        else $error("state not reset while disabled");
    a_lock_addr: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.run && !start_fetch
        |=> $stable(end_addr_ff))
        else $error("end address changed while running");
    a_yield_blocks: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.yield && IRQ_ACTIVE_IN
        && ctl_ff.mode != MODE_PEEK |-> !start_fetch)
        else $error("fetch during yielded interrupt");
    a_halt_freezes: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) DEBUG_HALT_IN |-> !start_fetch)
        else $error("fetch during debug halt");
    a_invalid_top: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) cur_addr_ff == MEM_WORDS
        |-> !start_fetch)
        else $error("fetch from address past memory");
    a_trig_gates_req: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.mode == MODE_TRIGGERED && !wr_en
        && !trig_edge && !pending_ff |=> !pending_ff)
        else $error("ready taken without a trigger edge");
    a_peek_no_yield: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.mode == MODE_PEEK && ctl_ff.enable
        && ctl_ff.run && pending_ff && state_ff == S_IDLE && !DEBUG_HALT_IN
        && !addr_invalid && cur_addr_ff <= end_addr_ff |-> start_fetch)
        else $error("peek fetch held back by an interrupt");
    // Outputs seen by the cpu, by the crc client and by software
    a_burst_stalls: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.enable && ctl_ff.run
        && ctl_ff.mode == MODE_BURST && !IRQ_ACTIVE_IN |-> CPU_STALL_OUT)
        else $error("cpu not stalled during burst");
    a_stall_burst_only: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.mode != MODE_BURST |-> !CPU_STALL_OUT)
        else $error("cpu stalled outside burst");
    a_yield_keeps_run: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) ctl_ff.run && ctl_ff.enable && !done_evt
        && !wr_en |=> ctl_ff.run)
        else $error("run bit cleared by a suspension");
    a_crc_gets_word: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) MEM_REQ_OUT |=> CRC_VALID_OUT
        && CRC_DATA_OUT == $past(MEM_DATA_IN))
        else $error("crc word differs from memory word");
    a_invalid_flags: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) addr_invalid && ctl_ff.enable
        |=> irq_status_ff[BIT_IRQ_INVALID])
        else $error("invalid address not flagged");
    a_busy_pending: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) (pending_ff || MEM_REQ_OUT)
        && PADDR_IN == OFF_CONTROL |-> PRDATA_OUT[BIT_BUSY])
        else $error("busy clear while a cycle is open");
    a_halt_keeps_run: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) DEBUG_HALT_IN && ctl_ff.run && ctl_ff.enable
        && !wr_en |=> ctl_ff.run)
        else $error("run cleared under a debug halt");
    a_disable_keeps: assert property (@(posedge CORE_CLK_IN)
        disable iff (RESET_IN) !ctl_ff.enable && !wr_en
        |=> $stable(cur_addr_ff) && $stable(end_addr_ff)
        && $stable(trig_sel_ff))
        else $error("register changed while scanner disabled");
endmodule

// [design/scan_pkg.sv]
// Package for the program-memory scanner: register map, fields, types.
// Assumes a 32-bit APB slave with one byte register per aligned word.
package scan_pkg;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CUR_HI = 8'h04;
    localparam logic [7:0] OFF_CUR_LO = 8'h08;
    localparam logic [7:0] OFF_END_HI = 8'h0c;
    localparam logic [7:0] OFF_END_LO = 8'h10;
    localparam logic [7:0] OFF_TRIG = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
    localparam int BIT_ENABLE = 7;
    localparam int BIT_RUN = 6;
    localparam int BIT_BUSY = 5;
    localparam int BIT_INVALID = 4;
    localparam int BIT_YIELD = 3;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_IRQ_DONE = 0;
    localparam int BIT_IRQ_INVALID = 1;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] MEM_WORDS_DEFAULT = 16'h4000;
    localparam logic [7:0] REG_RESET = 8'h00;
    typedef enum logic [1:0] {
        MODE_CONCURRENT = 2'b00,
        MODE_BURST = 2'b01,
        MODE_PEEK = 2'b10,
        MODE_TRIGGERED = 2'b11
    } access_mode_t;
    typedef struct packed {
        logic enable;
        logic run;
        logic yield;
        access_mode_t mode;
    } control_t;
    typedef struct packed {
        logic req;
        logic [15:0] addr;
    } mem_req_t;
endpackage

// [verif/crc_client_model.sv]
// CRC client model: asks for one word at a time and keeps the last one.
// Assumes a combinational memory image derived from the fetch address.
`timescale 1ns/1ns
module crc_client_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Scanner side
    input wire logic valid_in,
    input wire logic [13:0] data_in,
    input wire logic [15:0] mem_addr_in,
    output logic ready_out,
    output logic [13:0] mem_data_out,
    // Bench control
    input wire logic [7:0] limit_in,
    input wire logic [3:0] gap_in,
    output logic [7:0] cnt_out,
    output logic [13:0] last_out
);
    logic [3:0] wait_ff;
    // Neighbouring words differ, so a skipped or repeated fetch shows
    assign mem_data_out = mem_addr_in[13:0] ^ 14'h1555;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
            cnt_out <= 8'h00;
            last_out <= 14'h0000;
            wait_ff <= 4'h0;
        end else begin
            ready_out <= 1'b0;
            if (valid_in) begin
                cnt_out <= cnt_out + 8'h01;
                last_out <= data_in;
                wait_ff <= gap_in;
            end else if (wait_ff != 4'h0) begin
                wait_ff <= wait_ff - 4'h1;
            end else if (cnt_out < limit_in && !ready_out) begin
                // Ask again later: a trigger may not have coincided
                ready_out <= 1'b1;
                wait_ff <= 4'h8;
            end
        end
    end
endmodule

// [verif/test_nvm_memory_scanner.sv]
// Testbench for the scanner: APB register tasks and a CRC client model.
// Assumes the scanner answers APB without error and one fetch per ready.
`timescale 1ns/1ns
module test_nvm_memory_scanner;
    import scan_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mreq, valid, ready, stall, irq;
    logic [15:0] maddr, ea;
    logic [13:0] mdata, cdata, last;
    logic irq_act = 1'b0, halt = 1'b0;
    logic [3:0] src = 4'h0, tog = 4'h0, gap = 4'h0;
    logic [7:0] limit = 8'h00, cnt;
    logic [7:0] offs [9] = '{OFF_CONTROL, OFF_CUR_HI, OFF_CUR_LO,
        OFF_END_HI, OFF_END_LO, OFF_TRIG, OFF_IRQ_STATUS, OFF_IRQ_MASK,
        8'h20};
    int miscompares = 0, checked = 0;
    logic [7:0] nreq = 8'h00;
    always #50 clk = ~clk;
    always @(posedge clk) src <= src ^ tog;
    // Memory requests seen on the read port, one per delivered word
    always @(posedge clk) if (mreq === 1'b1) nreq <= nreq + 8'h01;
    nvm_memory_scanner #(.MEM_WORDS(16'h0040)) uut (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .MEM_REQ_OUT(mreq), .MEM_ADDR_OUT(maddr),
        .MEM_DATA_IN(mdata), .CRC_READY_IN(ready), .CRC_VALID_OUT(valid),
        .CRC_DATA_OUT(cdata), .IRQ_ACTIVE_IN(irq_act),
        .DEBUG_HALT_IN(halt), .LOW_FREQ_INTERNAL_OSC_IN(src[0]),
        .TIMER_TWO_POST_OUTPUT_IN(src[1]),
        .TIMER_FOUR_POST_OUTPUT_IN(src[2]),
        .TIMER_SIX_POST_OUTPUT_IN(src[3]), .CPU_STALL_OUT(stall),
        .IRQ_OUT(irq));
    crc_client_model client (.clk_in(clk), .rst_in(rst), .valid_in(valid),
        .data_in(cdata), .mem_addr_in(maddr), .ready_out(ready),
        .mem_data_out(mdata), .limit_in(limit), .gap_in(gap),
        .cnt_out(cnt), .last_out(last));
    task conclude;
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // The transfer lands at the rising edge that sees pready high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        cmp({31'h0, pready}, 32'h1);
        cmp({31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        cmp(rd & m, e);
    endtask
    task take;
        int i;
        for (i = 0; i < 200 && cnt !== limit; i++) @(posedge clk);
        cmp(32'(cnt), 32'(limit));
        cmp(32'(last), 32'(ea[13:0] ^ 14'h1555));
        ea = ea + 16'h1;
    endtask
    task req;
        limit <= limit + 8'h01;
        @(posedge clk);
    endtask
    task grab;
        req();
        take();
    endtask
    task stuck;
        req();
        repeat (30) @(posedge clk);
        cmp(32'(cnt), 32'(limit - 8'h01));
    endtask
    // Release right after a ready pulse so no retry lands mid-fetch
    task resume;
        int i;
        for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        irq_act <= 1'b0;
        halt <= 1'b0;
        take();
    endtask
    initial begin
        #2000000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[k]) rchk(offs[k], 32'h0, 32'hff);
        wr(OFF_IRQ_MASK, 32'h0);
        wr(OFF_END_HI, 32'h0);
        wr(OFF_END_LO, 32'h12);
        wr(OFF_CUR_HI, 32'h0);
        wr(OFF_CUR_LO, 32'h10);
        wr(OFF_TRIG, 32'h2);
        rchk(OFF_TRIG, 32'h2, 32'hff);
        wr(OFF_CONTROL, 32'hc0);
        rchk(OFF_CONTROL, 32'hc0, 32'hff);
        wr(OFF_CUR_LO, 32'h55);
        rchk(OFF_CUR_LO, 32'h10, 32'hff);
        wr(OFF_END_LO, 32'h77);
        rchk(OFF_END_LO, 32'h12, 32'hff);
        ea = 16'h10;
        grab();
        gap <= 4'h3;
        grab();
        grab();
        repeat (5) @(posedge clk);
        rchk(OFF_CONTROL, 32'h80, 32'hff);
        rchk(OFF_CUR_LO, 32'h13, 32'hff);
        @(negedge clk);
        cmp({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h3);
        @(negedge clk);
        cmp({31'h0, irq}, 32'h1);
        rchk(OFF_IRQ_STATUS, 32'h1, 32'hff);
        @(negedge clk);
        cmp({31'h0, irq}, 32'h0);
        wr(OFF_END_LO, 32'h30);
        wr(OFF_CONTROL, 32'hc0);
        wr(OFF_CONTROL, 32'h0);
        rchk(OFF_CONTROL, 32'h0, 32'hff);
        rchk(OFF_CUR_LO, 32'h13, 32'hff);
        rchk(OFF_END_LO, 32'h30, 32'hff);
        rchk(OFF_TRIG, 32'h2, 32'hff);
        gap <= 4'h0;
        irq_act <= 1'b1;
        wr(OFF_CONTROL, 32'hc8);
        stuck();
        rchk(OFF_CONTROL, 32'he8, 32'hff);
        resume();
        halt <= 1'b1;
        stuck();
        resume();
        irq_act <= 1'b1;
        wr(OFF_CONTROL, 32'hc0);
        grab();
        wr(OFF_CONTROL, 32'hca);
        grab();
        irq_act <= 1'b0;
        wr(OFF_CONTROL, 32'hc9);
        @(negedge clk);
        cmp({31'h0, stall}, 32'h1);
        grab();
        irq_act <= 1'b1;
        stuck();
        resume();
        wr(OFF_CONTROL, 32'hc3);
        @(negedge clk);
        cmp({31'h0, stall}, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(OFF_TRIG, 32'(s));
            tog <= 4'(1 << ((s + 1) % 4));
            stuck();
            tog <= 4'(1 << s);
            take();
        end
        tog <= 4'h0;
        wr(OFF_CONTROL, 32'h80);
        wr(OFF_CUR_LO, 32'h3f);
        wr(OFF_END_LO, 32'h3f);
        wr(OFF_CONTROL, 32'hc0);
        ea = 16'h3f;
        grab();
        repeat (5) @(posedge clk);
        rchk(OFF_CONTROL, 32'h90, 32'hff);
        rchk(OFF_IRQ_STATUS, 32'h3, 32'hff);
        wr(OFF_CUR_LO, 32'h10);
        rchk(OFF_CONTROL, 32'h80, 32'hff);
        cmp(32'(nreq), 32'(limit));
        conclude();
    end
endmodule
